/* rtl/windowed_watchdog_timer.sv */
// Windowed watchdog timer with APB register access
// Notes on behaviour
// RULE1: Count reaching the period without a valid clear forces a system reset.
// RULE2: Time base is the 31 kHz or the 31.25 kHz internal oscillator.
// RULE3: Enable mode 1x takes the clock source from the configuration field.
// RULE4: Enable mode 01 needs software enable; runtime field picks the clock.
// RULE5: Mode 11 always on, 10 awake only, 01 software, 00 off.
// RULE6: Configuration prescale all ones lets runtime prescale choose the period.
// RULE7: After reset the period is nominally two seconds.
// RULE8: Configuration window 111 lets the runtime window field choose.
// RULE9: Open window spans 12.5% up to 100% of the period.
// RULE10: Clear while window closed is a violation and resets the device.
// RULE11: Window opening compares upper count bits with the window threshold.
// RULE12: Violation clears the violation flag; only reset or software sets it.
// RULE13: Count clears on reset, clear, sleep, wake, disable, startup, failure, writes.
// RULE14: Windowed clears need a prior read of control register 0.
// RULE15: Unarmed clear is a violation even with the window open.
// RULE16: Count clears on sleep entry, may keep counting, clears on exit.
// RULE17: Count held clear while startup timer runs; divider changes ignored.
// RULE18: Timeout in sleep wakes instead of resetting and updates status bits.
// RULE19: Prescale 00000 is 1:32, doubling to 10010; higher codes are minimum.
// RULE20: Window 000 opens the last 12.5%, 12.5% more per step to 111.
// RULE21: Software enable is control register 0 bit 0, used only in mode 01.
// RULE22: Each clear consumes the arming; the next needs a fresh read.
// RULE23: Prescaler and timer count ticks; timeout at the selected ratio.
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module windowed_watchdog_timer #(
  parameter int CNT_W = 23
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_low_freq_osc,
  input wire logic i_mid_freq_osc,
  input wire logic [1:0] i_cfg_enable_mode,
  input wire logic [2:0] i_cfg_clock_source,
  input wire logic [4:0] i_cfg_prescale,
  input wire logic [2:0] i_cfg_window_size,
  input wire logic i_clear_watchdog_instr,
  input wire logic i_sleep_enter,
  input wire logic i_sleep_exit,
  input wire logic i_osc_startup_timer,
  input wire logic i_osc_fail,
  output logic o_wdt_reset,
  output logic o_wake
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for pins and straps

  localparam int SYNC_W = 15;

  logic [SYNC_W-1:0] meta_r;
  logic [SYNC_W-1:0] sync_r;
  logic [1:0] osc_last_r;
  logic [1:0] cfg_mode;
  logic [2:0] cfg_clk;
  logic [4:0] cfg_ps;
  logic [2:0] cfg_win;
  logic [1:0] osc_now;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= {i_low_freq_osc, i_mid_freq_osc, i_cfg_enable_mode,
                 i_cfg_clock_source, i_cfg_prescale, i_cfg_window_size};
      sync_r <= meta_r;
    end
  end

  assign osc_now = sync_r[14:13];
  assign cfg_mode = sync_r[12:11];
  assign cfg_clk = sync_r[10:8];
  assign cfg_ps = sync_r[7:3];
  assign cfg_win = sync_r[2:0];

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      osc_last_r <= '0;
    end else begin
      osc_last_r <= osc_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave

  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic access;
  logic done;
  logic wr_done;
  logic rd_done;
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic wr_cause;
  logic mapped;
  logic [31:0] read_mux;

  assign access = i_psel && i_penable && !pready_r;
  assign done = i_psel && i_penable && pready_r;
  assign wr_done = done && i_pwrite;
  assign rd_done = done && !i_pwrite;
  assign wr_ctrl0 = wr_done && (i_paddr == wdt_pkg::OFF_CONTROL_REG0);
  assign wr_ctrl1 = wr_done && (i_paddr == wdt_pkg::OFF_CONTROL_REG1);
  assign wr_cause = wr_done && (i_paddr == wdt_pkg::OFF_RESET_CAUSE_REG);

  always_comb begin
    mapped = (i_paddr == wdt_pkg::OFF_CONTROL_REG0) ||
             (i_paddr == wdt_pkg::OFF_CONTROL_REG1) ||
             (i_paddr == wdt_pkg::OFF_COUNT) ||
             (i_paddr == wdt_pkg::OFF_TIMER) ||
             (i_paddr == wdt_pkg::OFF_RESET_CAUSE_REG);
  end

  // One wait state: ready rises in the second access cycle
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= access;
      pslverr_r <= access && !mapped;
      if (access && !i_pwrite) begin
        prdata_r <= read_mux;
      end else if (done) begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  logic sw_enable_r;
  logic [4:0] rt_ps_r;
  logic [2:0] rt_clk_r;
  logic [2:0] rt_win_r;
  logic [4:0] eff_ps;
  logic [2:0] eff_clk;
  logic [2:0] eff_win;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      sw_enable_r <= 1'b0;
      rt_ps_r <= wdt_pkg::PRESCALE_RESET; // [RULE7]
    end else if (wr_ctrl0) begin
      sw_enable_r <= i_pwdata[wdt_pkg::SW_ENABLE_BIT]; // [RULE21]
      if (cfg_ps == wdt_pkg::PRESCALE_FROM_REG) begin
        rt_ps_r <= i_pwdata[wdt_pkg::PRESCALE_LSB +: 5];
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rt_clk_r <= wdt_pkg::CLK_LOW_FREQ;
      rt_win_r <= wdt_pkg::WINDOW_FULL;
    end else if (wr_ctrl1) begin
      if (cfg_clk == wdt_pkg::CLK_FROM_REG) begin
        rt_clk_r <= i_pwdata[wdt_pkg::CLOCK_SELECT_LSB +: 3];
      end
      if (cfg_win == wdt_pkg::WINDOW_FULL) begin
        rt_win_r <= i_pwdata[wdt_pkg::WINDOW_LSB +: 3];
      end
    end
  end

  always_comb begin
    eff_ps = (cfg_ps == wdt_pkg::PRESCALE_FROM_REG) ? rt_ps_r : cfg_ps; // [RULE6]
    eff_win = (cfg_win == wdt_pkg::WINDOW_FULL) ? rt_win_r : cfg_win; // [RULE8]
    if (cfg_mode[1]) begin
      eff_clk = cfg_clk; // [RULE3]
    end else begin
      eff_clk = rt_clk_r; // [RULE4]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode, arming and sleep

  logic sleeping_r;
  logic armed_r;
  logic active;
  logic windowed;
  logic window_open;
  logic clr;
  logic valid_clear;
  logic violation;
  logic tick;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      sleeping_r <= 1'b0;
    end else if (i_sleep_enter) begin
      sleeping_r <= 1'b1;
    end else if (i_sleep_exit) begin
      sleeping_r <= 1'b0;
    end
  end

  always_comb begin
    unique case (cfg_mode) // [RULE5]
      wdt_pkg::MODE_ALWAYS: active = 1'b1;
      wdt_pkg::MODE_AWAKE: active = !sleeping_r;
      wdt_pkg::MODE_SOFTWARE: active = sw_enable_r; // [RULE4] [RULE21]
      wdt_pkg::MODE_OFF: active = 1'b0;
    endcase
  end

  // Reserved clock codes give no ticks
  always_comb begin
    unique case (eff_clk) // [RULE2]
      wdt_pkg::CLK_LOW_FREQ: tick = osc_now[1] && !osc_last_r[1];
      wdt_pkg::CLK_MID_FREQ: tick = osc_now[0] && !osc_last_r[0];
      default: tick = 1'b0;
    endcase
  end

  wdt_count_if #(.CNT_W(CNT_W)) cnt_if ();

  function automatic logic [4:0] ratio_exponent(input logic [4:0] code);
    if (code > wdt_pkg::PRESCALE_MAX_CODE) begin
      ratio_exponent = wdt_pkg::PRESCALE_BASE_EXP;
    end else begin
      ratio_exponent = code + wdt_pkg::PRESCALE_BASE_EXP;
    end
  endfunction

  // Open when upper three count bits reach 7 - window code
  always_comb begin
    windowed = (eff_win != wdt_pkg::WINDOW_FULL);
    window_open = (cnt_if.top_bits[4:2] >= (3'h7 - eff_win)); // [RULE11] [RULE9] [RULE20]
    clr = i_clear_watchdog_instr && active;
    valid_clear = clr && (!windowed || (armed_r && window_open)); // [RULE14]
    violation = clr && windowed && (!armed_r || !window_open); // [RULE10] [RULE15]
  end

  // Read of control register 0 arms; each clear consumes it, read wins
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      armed_r <= 1'b0;
    end else if (rd_done && (i_paddr == wdt_pkg::OFF_CONTROL_REG0)) begin
      armed_r <= 1'b1; // [RULE14]
    end else if (i_clear_watchdog_instr) begin
      armed_r <= 1'b0; // [RULE22]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter

  assign cnt_if.tick = tick && active;
  assign cnt_if.exponent = ratio_exponent(eff_ps); // [RULE19]
  assign cnt_if.clear = valid_clear || violation || i_sleep_enter ||
                        i_sleep_exit || !active || i_osc_startup_timer ||
                        i_osc_fail || wr_ctrl0 || wr_ctrl1; // [RULE13] [RULE16] [RULE17]

  wdt_counter #(.CNT_W(CNT_W)) u_counter (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .port(cnt_if.counter)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Reset and wake outputs, status flags

  logic wdt_reset_r;
  logic wake_r;
  logic viol_flag_r;
  logic timeout_flag_r;
  logic expiry_r;
  logic powerdown_r;
  logic timeout_awake;
  logic timeout_asleep;

  assign timeout_awake = cnt_if.timeout && !sleeping_r;
  assign timeout_asleep = cnt_if.timeout && sleeping_r;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      wdt_reset_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      wdt_reset_r <= timeout_awake || violation; // [RULE1] [RULE10]
      wake_r <= timeout_asleep; // [RULE18]
    end
  end

  // Flags are active low; hardware clearing wins over a software write
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      viol_flag_r <= 1'b1;
      timeout_flag_r <= 1'b1;
    end else begin
      if (violation) begin
        viol_flag_r <= 1'b0; // [RULE12]
      end else if (wr_cause) begin
        viol_flag_r <= i_pwdata[wdt_pkg::VIOLATION_BIT]; // [RULE12]
      end
      if (cnt_if.timeout) begin
        timeout_flag_r <= 1'b0; // [RULE18]
      end else if (wr_cause) begin
        timeout_flag_r <= i_pwdata[wdt_pkg::TIMEOUT_FLAG_BIT];
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      expiry_r <= 1'b1;
      powerdown_r <= 1'b1;
    end else if (timeout_asleep) begin
      expiry_r <= 1'b0; // [RULE18]
      powerdown_r <= 1'b0;
    end else if (timeout_awake) begin
      expiry_r <= 1'b0;
    end else if (i_sleep_enter) begin
      powerdown_r <= 1'b0;
    end else if (i_clear_watchdog_instr) begin
      expiry_r <= 1'b1;
      powerdown_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  always_comb begin
    read_mux = 32'h0000_0000;
    unique case (i_paddr)
      wdt_pkg::OFF_CONTROL_REG0: begin
        read_mux[wdt_pkg::SW_ENABLE_BIT] = sw_enable_r;
        read_mux[wdt_pkg::PRESCALE_LSB +: 5] = eff_ps;
      end
      wdt_pkg::OFF_CONTROL_REG1: begin
        read_mux[wdt_pkg::CLOCK_SELECT_LSB +: 3] = eff_clk;
        read_mux[wdt_pkg::WINDOW_LSB +: 3] = eff_win;
      end
      wdt_pkg::OFF_COUNT: begin
        read_mux[CNT_W-1:0] = cnt_if.count;
      end
      wdt_pkg::OFF_TIMER: begin
        read_mux[wdt_pkg::TMR_VALUE_LSB +: 5] = cnt_if.top_bits;
        read_mux[wdt_pkg::TMR_ARMED_BIT] = armed_r;
        read_mux[wdt_pkg::TMR_ACTIVE_BIT] = active;
      end
      wdt_pkg::OFF_RESET_CAUSE_REG: begin
        read_mux[wdt_pkg::VIOLATION_BIT] = viol_flag_r;
        read_mux[wdt_pkg::TIMEOUT_FLAG_BIT] = timeout_flag_r;
        read_mux[wdt_pkg::EXPIRY_BIT] = expiry_r;
        read_mux[wdt_pkg::POWERDOWN_BIT] = powerdown_r;
      end
      default: read_mux = 32'h0000_0000;
    endcase
  end

  assign o_prdata = prdata_r;
  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_wdt_reset = wdt_reset_r;
  assign o_wake = wake_r;

endmodule // windowed_watchdog_timer
`default_nettype wire

/* rtl/wdt_pkg.sv */
// Shared constants for the windowed watchdog timer
package wdt_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] OFF_CONTROL_REG0 = 8'h00;
  localparam logic [7:0] OFF_CONTROL_REG1 = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_TIMER = 8'h0C;
  localparam logic [7:0] OFF_RESET_CAUSE_REG = 8'h10;

  // Control register 0 fields
  localparam int SW_ENABLE_BIT = 0;
  localparam int PRESCALE_LSB = 1;
  // Control register 1 fields
  localparam int WINDOW_LSB = 0;
  localparam int CLOCK_SELECT_LSB = 4;
  // Timer register fields
  localparam int TMR_ACTIVE_BIT = 1;
  localparam int TMR_ARMED_BIT = 2;
  localparam int TMR_VALUE_LSB = 3;
  // Reset-cause register fields
  localparam int POWERDOWN_BIT = 0;
  localparam int EXPIRY_BIT = 1;
  localparam int TIMEOUT_FLAG_BIT = 4;
  localparam int VIOLATION_BIT = 5;

  // Enable modes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SOFTWARE = 2'h1;
  localparam logic [1:0] MODE_AWAKE = 2'h2;
  localparam logic [1:0] MODE_ALWAYS = 2'h3;

  // Clock source codes
  localparam logic [2:0] CLK_LOW_FREQ = 3'h0;
  localparam logic [2:0] CLK_MID_FREQ = 3'h1;
  localparam logic [2:0] CLK_FROM_REG = 3'h7;

  // Prescale codes: ratio is 2^(code + PRESCALE_BASE_EXP) up to PRESCALE_MAX_CODE, 2^PRESCALE_BASE_EXP above it
  localparam logic [4:0] PRESCALE_FROM_REG = 5'h1F;
  localparam logic [4:0] PRESCALE_MAX_CODE = 5'h12;
  localparam logic [4:0] PRESCALE_RESET = 5'h0B;
  localparam logic [4:0] PRESCALE_BASE_EXP = 5'h05;
  localparam int COUNT_WIDTH = 23;

  // Window codes
  localparam logic [2:0] WINDOW_FULL = 3'h7;

  // Nominal oscillator rates in Hz
  localparam int LOW_FREQ_OSC_HZ = 31000;
  localparam int MID_FREQ_OSC_HZ = 31250;

endpackage

/* rtl/wdt_count_if.sv */
// Carrier between the watchdog control logic and its counter
`timescale 1ns/1ns
`default_nettype none
interface wdt_count_if #(parameter int CNT_W = 23);
  logic tick;
  logic clear;
  logic [4:0] exponent;
  logic timeout;
  logic [4:0] top_bits;
  logic [CNT_W-1:0] count;

  modport control (
    output tick,
    output clear,
    output exponent,
    input timeout,
    input top_bits,
    input count
  );

  modport counter (
    input tick,
    input clear,
    input exponent,
    output timeout,
    output top_bits,
    output count
  );
endinterface
`default_nettype wire

/* rtl/wdt_counter.sv */
// Prescaler and timer counting watchdog clock ticks
`timescale 1ns/1ns
`default_nettype none
module wdt_counter #(
  parameter int CNT_W = 23
) (
  input wire logic i_clock,
  input wire logic i_srst,
  wdt_count_if.counter port
);

  if (CNT_W < wdt_pkg::COUNT_WIDTH || CNT_W > 32) begin : g_check
    $error("wdt_counter: CNT_W must lie between 23 and 32");
  end

  logic [CNT_W-1:0] count_r;
  logic timeout_r;
  logic [CNT_W-1:0] last_count;
  logic [CNT_W-1:0] aligned;

  always_comb begin
    last_count = CNT_W'((64'd1 << port.exponent) - 64'd1);
    // Upper bits of the count relative to the selected period
    aligned = count_r << (CNT_W - int'(port.exponent));
  end

  always_ff @(posedge i_clock) begin
    if (i_srst || port.clear) begin
      count_r <= '0;
    end else if (port.tick) begin
      if (count_r >= last_count) begin
        count_r <= '0;
      end else begin
        count_r <= count_r + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      timeout_r <= 1'b0;
    end else begin
      timeout_r <= port.tick && !port.clear && (count_r >= last_count); // [RULE23]
    end
  end

  assign port.timeout = timeout_r;
  assign port.top_bits = aligned[CNT_W-1 -: 5];
  assign port.count = count_r;

endmodule // wdt_counter
`default_nettype wire

/* test/wdt_core_model.sv */
// Core-side model: watchdog oscillators, clear and sleep signalling
`timescale 1ns/1ns
`default_nettype none
module core_model (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic [2:0] i_req,
  input wire logic i_wake,
  output logic o_low_osc,
  output logic o_mid_osc,
  output logic o_clear,
  output logic o_sleep_enter,
  output logic o_sleep_exit
);
  logic [2:0] div_r;
  // Four clock cycles per oscillator level, one tick every eight
  always_ff @(posedge i_clock) begin
    div_r <= i_srst ? 3'h0 : div_r + 3'h1;
  end
  assign o_low_osc = div_r[2];
  assign o_mid_osc = ~div_r[2];
  // One-cycle pulses; a wake from the watchdog ends sleep in the cycle after it
  always_ff @(posedge i_clock) begin
    o_clear <= i_req[0] & ~i_srst;
    o_sleep_enter <= i_req[1] & ~i_srst;
    o_sleep_exit <= (i_req[2] | i_wake) & ~i_srst;
  end
endmodule // core_model
`default_nettype wire

/* test/wdt_props.sv */
// Port-level checker for the windowed watchdog timer
`timescale 1ns/1ns
`default_nettype none
module wdt_props (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [1:0] i_cfg_enable_mode,
  input wire logic o_wdt_reset,
  input wire logic o_wake
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_srst);
  property p_pready_wait;
    i_psel && i_penable && !$past(i_penable) |-> !o_pready ##1 o_pready;
  endproperty
  a_pready_wait: assert property (p_pready_wait)
    else $error("pready not after one wait state");
  property p_pready_once;
    o_pready |=> !o_pready;
  endproperty
  a_pready_once: assert property (p_pready_once)
    else $error("pready held too long");
  property p_pready_access;
    o_pready |-> i_psel && i_penable;
  endproperty
  a_pready_access: assert property (p_pready_access)
    else $error("pready outside access phase");
  property p_slverr;
    o_pready && i_paddr[1:0] == 2'b00 |-> o_pslverr == (i_paddr > 8'h10);
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("slave error wrong for address");
  property p_prdata_idle;
    !o_pready || o_pslverr |-> o_prdata == 32'h0000_0000;
  endproperty
  a_prdata_idle: assert property (p_prdata_idle)
    else $error("read data not zero");
  property p_reset_pulse;
    o_wdt_reset |=> !o_wdt_reset;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse)
    else $error("reset request longer than one cycle");
  property p_wake_pulse;
    $rose(o_wake) |=> $fell(o_wake);
  endproperty
  a_wake_pulse: assert property (p_wake_pulse)
    else $error("wake longer than one cycle");
  property p_exclusive;
    !(o_wdt_reset && o_wake);
  endproperty
  a_exclusive: assert property (p_exclusive)
    else $error("wake and reset together");
  property p_off_quiet;
    i_cfg_enable_mode == 2'b00 [*6] |=> !o_wdt_reset && !o_wake;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("event while watchdog off");
  c_reset: cover property (o_wdt_reset);
  c_wake: cover property (o_wake);
  c_slverr: cover property (o_pready && o_pslverr);
endmodule // wdt_props
bind windowed_watchdog_timer wdt_props wdt_props_i (.i_clock(i_clock),
  .i_srst(i_srst), .i_psel(i_psel), .i_penable(i_penable),
  .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_cfg_enable_mode(i_cfg_enable_mode),
  .o_wdt_reset(o_wdt_reset), .o_wake(o_wake));
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the windowed watchdog timer
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin \
  err_total++; $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module testbench;
  logic clk = 0, srst = 1, psel = 0, pen = 0, pwr = 0, err, pready, slverr;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, rd, prdata;
  logic [1:0] mode = 2'h0;
  logic [2:0] ccs = 3'h0, cws = 3'h7, req = 3'h0;
  logic [4:0] cps = 5'h1F;
  logic lo, mid, clr, s_in, s_out, wdt_rst, wake, seen_r, seen_w;
  logic osc_startup_timer = 0, ofail = 0;
  int err_total = 0, check_count = 0, first;
  windowed_watchdog_timer windowed_watchdog_timer_i (.i_clock(clk),
    .i_srst(srst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(addr), .i_pwdata(wdat), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(slverr), .i_low_freq_osc(lo), .i_mid_freq_osc(mid),
    .i_cfg_enable_mode(mode), .i_cfg_clock_source(ccs),
    .i_cfg_prescale(cps), .i_cfg_window_size(cws),
    .i_clear_watchdog_instr(clr), .i_sleep_enter(s_in),
    .i_sleep_exit(s_out), .i_osc_startup_timer(osc_startup_timer), .i_osc_fail(ofail),
    .o_wdt_reset(wdt_rst), .o_wake(wake));
  core_model core_model_i (.i_clock(clk), .i_srst(srst), .i_req(req),
    .i_wake(wake), .o_low_osc(lo), .o_mid_osc(mid), .o_clear(clr),
    .o_sleep_enter(s_in), .o_sleep_exit(s_out));
  //////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    psel <= 1;
    pwr <= w;
    addr <= a;
    wdat <= d;
    @(posedge clk);
    pen <= 1;
    n = 0;
    // Ready, data and error are taken at the rising edge that ends access
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = slverr;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  task automatic watch(input int n);
    seen_r = 0;
    seen_w = 0;
    first = -1;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      if (wdt_rst === 1'b1 && first < 0) first = i;
      seen_r |= (wdt_rst === 1'b1);
      seen_w |= (wake === 1'b1);
    end
    @(posedge clk);
  endtask
  task automatic pulse(input int k);
    req[k] <= 1;
    @(posedge clk);
    req[k] <= 0;
  endtask
  // New mode, then a control write to restart the count
  task automatic restart(input logic [1:0] m, input logic [2:0] win);
    mode <= m;
    repeat (4) @(posedge clk);
    apb(1, 8'h04, {29'h0000_0000, win});
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    apb(0, 8'h00, 0);
    `CHK("ctrl0", 32'h0000_0016, rd)
    apb(0, 8'h10, 0);
    `CHK("cause", 32'h0000_0033, rd)
    apb(0, 8'h40, 0);
    `CHK("unmapped", 1'b1, err)
    apb(1, 8'h00, 32'h0000_0024);
    apb(0, 8'h00, 0);
    `CHK("prescale", 32'h0000_0024, rd)
    apb(1, 8'h00, 32'h0000_0000);
    $display("t_reset done");
  endtask
  task automatic t_timeout;
    restart(2'b11, 3'h7);
    watch(320);
    `CHK("timeout", 1'b1, seen_r)
    `CHK("period", 1'b1, first >= 240 && first <= 280)
    apb(0, 8'h10, 0);
    `CHK("to_flag", 1'b0, rd[4])
    apb(1, 8'h10, 32'h0000_0030);
    $display("t_timeout done");
  endtask
  task automatic t_window;
    restart(2'b11, 3'h3);
    apb(0, 8'h04, 0);
    `CHK("win", 32'h0000_0003, rd)
    repeat (175) @(posedge clk);
    apb(0, 8'h00, 0);
    pulse(0);
    watch(120);
    `CHK("armed_clr", 1'b0, seen_r)
    repeat (60) @(posedge clk);
    pulse(0);
    watch(6);
    `CHK("rearm", 1'b1, seen_r)
    apb(0, 8'h10, 0);
    `CHK("viol_flag", 1'b0, rd[5])
    apb(1, 8'h10, 32'h0000_0030);
    apb(0, 8'h00, 0);
    pulse(0);
    watch(6);
    `CHK("closed_clr", 1'b1, seen_r)
    apb(1, 8'h10, 32'h0000_0030);
    $display("t_window done");
  endtask
  task automatic t_modes;
    restart(2'b00, 3'h7);
    watch(320);
    `CHK("off", 1'b0, seen_r)
    restart(2'b01, 3'h7);
    watch(320);
    `CHK("sw_off", 1'b0, seen_r)
    apb(1, 8'h00, 32'h0000_0001);
    watch(320);
    `CHK("sw_on", 1'b1, seen_r)
    apb(1, 8'h00, 32'h0000_0000);
    $display("t_modes done");
  endtask
  // Mid-frequency source; startup timer holds, oscillator failure clears
  task automatic t_hold;
    ccs <= 3'h1;
    restart(2'b11, 3'h7);
    osc_startup_timer <= 1;
    watch(320);
    `CHK("ost_hold", 1'b0, seen_r)
    osc_startup_timer <= 0;
    repeat (200) @(posedge clk);
    ofail <= 1;
    @(posedge clk);
    ofail <= 0;
    watch(120);
    `CHK("fail_clr", 1'b0, seen_r)
    watch(200);
    `CHK("fail_run", 1'b1, seen_r)
    apb(1, 8'h10, 32'h0000_0030);
    $display("t_hold done");
  endtask
  task automatic t_sleep;
    restart(2'b10, 3'h7);
    pulse(1);
    watch(320);
    `CHK("awake_only", 1'b0, seen_r | seen_w)
    pulse(2);
    apb(1, 8'h10, 32'h0000_0030);
    restart(2'b11, 3'h7);
    pulse(1);
    watch(320);
    `CHK("wake", 1'b1, seen_w)
    `CHK("no_rst", 1'b0, seen_r)
    apb(0, 8'h10, 0);
    `CHK("sleep_flags", 6'h20, rd[5:0])
    $display("t_sleep done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (16) @(posedge clk);
    srst <= 0;
    repeat (3) @(posedge clk);
    t_reset;
    t_timeout;
    t_window;
    t_modes;
    t_hold;
    t_sleep;
    give_verdict;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    give_verdict;
  end
endmodule // testbench
`default_nettype wire
